/* File: logic/ums_defines.svh */
// Purpose: Constants for the modem status and scratch block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Definitions only.
`ifndef UMS_DEFINES_SVH
`define UMS_DEFINES_SVH
`define UMS_ADDR_W        12
`define UMS_OFF_STATUS    12'h000
`define UMS_OFF_SCRATCH   12'h004
`define UMS_OFF_CONTROL   12'h008
`define UMS_OFF_IRQ_STAT  12'h00C
`define UMS_OFF_IRQ_MASK  12'h010
`define UMS_CTL_RTS       0
`define UMS_CTL_DTR       1
`define UMS_CTL_OUT1      2
`define UMS_CTL_OUT2      3
`define UMS_CTL_LOOP      4
`define UMS_CTL_AUTOCTS   7
`define UMS_IRQ_MODEM     0
`define UMS_IRQ_TXSTOP    1
`define UMS_RESET_BYTE    8'h00
`define UMS_RESET_CTL     8'h00
`define UMS_RESET_MASK    2'h0
`define UMS_PIN_IDLE      1'b1
`define UMS_ZERO_WORD     32'h0000_0000
`endif

/* File: logic/ums_pkg.sv */
// Purpose: Types for the modem status and scratch block.
// Assumes: Constants come from ums_defines.svh.
// Notes: Modem lines carried as one struct.
package ums_pkg;
   typedef struct packed
   {
      logic cd;
      logic ri;
      logic dsr;
      logic cts;
   } ums_modem_s;
   typedef enum logic [1:0]
   {
      UMS_TX_RUN  = 2'b01,
      UMS_TX_HELD = 2'b10
   } ums_tx_e;
endpackage : ums_pkg

/* File: logic/ums_sync.sv */
// Purpose: Two-flop synchroniser for a bundle of asynchronous lines.
// Assumes: Lines are levels from outside the clock domain.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ps
`default_nettype none
module ums_sync
(
   // Clock and reset.
   input  wire logic       core_clk_in,
   input  wire logic       srst_in,
   // Lines.
   input  wire logic [3:0] async_in,
   output var  logic [3:0] sync_out
);
   logic [3:0] stage_one;
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         stage_one <= 4'hF;
         sync_out  <= 4'hF;
      end
      else
      begin
         stage_one <= async_in;
         sync_out  <= stage_one;
      end
   end
endmodule : ums_sync
`default_nettype wire

/* File: logic/ums_top.sv */
// Purpose: Modem input status, change flags, interrupt, auto flow gate and scratch byte.
// Assumes: APB slave, zero wait states; modem pins are active low and asynchronous.
// Notes: Unmapped addresses read zero and answer with pslverr.
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ums_defines.svh"
// Overview of operation
// - A change on a modem input sets its change flag in the low four status bits; for ring, only a rising pin does.
// - A host read of the status register clears the change flags that it returned.
// - Bit 7 reads inverted carrier detect, or the second user output in loop-back.
// - Bit 6 reads inverted ring indicator, or the first user output in loop-back.
// - Bit 5 reads inverted data-set-ready, or the DTR control bit in loop-back.
// - Bit 4 reads inverted clear-to-send, or the RTS control bit in loop-back.
// - With auto clear-to-send on, a high pin halts sending after the current character.
// - Carrier, data-set-ready and clear-to-send flags set on any transition.
// - The ring flag sets only when the ring pin goes from zero to one.
// - A modem interrupt is requested while any change flag is set.
// - An 8-bit scratch byte stores and returns what the host writes.
// - With auto clear-to-send on, sending resumes when the pin returns to zero.
module ums_top
   import ums_pkg::*;
(
   // Clock and reset.
   input  wire logic                   core_clk_in,
   input  wire logic                   srst_in,
   // APB slave.
   input  wire logic                   psel_in,
   input  wire logic                   penable_in,
   input  wire logic                   pwrite_in,
   input  wire logic [`UMS_ADDR_W-1:0] paddr_in,
   input  wire logic [31:0]            pwdata_in,
   input  wire logic [3:0]             pstrb_in,
   output var  logic [31:0]            prdata_out,
   output logic                        pready_out,
   output logic                        pslverr_out,
   // Modem pins, active low.
   input  wire logic                   cts_n_in,
   input  wire logic                   dsr_n_in,
   input  wire logic                   ri_n_in,
   input  wire logic                   cd_n_in,
   // Modem control outputs, active low.
   output logic                        rts_n_out,
   output logic                        dtr_n_out,
   output logic                        out1_n_out,
   output logic                        out2_n_out,
   // Transmitter handshake.
   input  wire logic                   tx_char_done_in,
   output logic                        tx_allow_out,
   // Interrupts.
   output logic                        modem_irq_out,
   output logic                        irq_out
);
   ums_modem_s pins_sync;
   ums_modem_s pins_prev;
   ums_modem_s level;
   logic [3:0] delta;
   logic [3:0] next_delta;
   logic [3:0] rise_evt;
   logic [7:0] scratch_storage;
   logic [7:0] modem_control_register;
   logic [1:0] irq_stat;
   logic [1:0] irq_mask;
   logic [1:0] irq_evt;
   logic       loop_mode;
   logic       auto_cts_enable;
   logic       cts_block;
   logic       wr_acc;
   logic       rd_acc;
   logic       mapped;
   logic [7:0] status_byte;
   logic       rd_setup;
   logic [7:0] rd_byte;
   ums_tx_e    tx_state;
   ums_tx_e    next_tx_state;

   assign wr_acc = psel_in & penable_in & pwrite_in & pstrb_in[0];
   assign rd_acc = psel_in & penable_in & ~pwrite_in;
   assign rd_setup = psel_in & ~penable_in & ~pwrite_in;
   assign pready_out = 1'b1;
   assign mapped = (paddr_in == `UMS_OFF_STATUS) | (paddr_in == `UMS_OFF_SCRATCH)
                 | (paddr_in == `UMS_OFF_CONTROL) | (paddr_in == `UMS_OFF_IRQ_STAT)
                 | (paddr_in == `UMS_OFF_IRQ_MASK);
   assign pslverr_out = psel_in & penable_in & ~mapped;
   assign loop_mode       = modem_control_register[`UMS_CTL_LOOP];
   assign auto_cts_enable = modem_control_register[`UMS_CTL_AUTOCTS];

   ums_sync u_sync
   (
      .core_clk_in (core_clk_in),
      .srst_in     (srst_in),
      .async_in    ({cd_n_in, ri_n_in, dsr_n_in, cts_n_in}),
      .sync_out    (pins_sync)
   );

   // Source of the sensed level per line, in pin polarity.
   always_comb
   begin
      if (loop_mode)
      begin
         level.cd  = ~modem_control_register[`UMS_CTL_OUT2];
         level.ri  = ~modem_control_register[`UMS_CTL_OUT1];
         level.dsr = ~modem_control_register[`UMS_CTL_DTR];
         level.cts = ~modem_control_register[`UMS_CTL_RTS];
      end
      else
      begin
         level = pins_sync;
      end
   end

   assign status_byte = {~level.cd, ~level.ri, ~level.dsr, ~level.cts, delta};

   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         pins_prev <= 4'hF;
      end
      else
      begin
         pins_prev <= level;
      end
   end

   assign rise_evt[3] = level.cd  ^ pins_prev.cd;
   assign rise_evt[2] = level.ri  & ~pins_prev.ri;
   assign rise_evt[1] = level.dsr ^ pins_prev.dsr;
   assign rise_evt[0] = level.cts ^ pins_prev.cts;

   // A read clears only the flags that it returned; a new set always wins.
   always_comb
   begin
      next_delta = delta;
      if (rd_acc && paddr_in == `UMS_OFF_STATUS)
      begin
         next_delta = delta & ~prdata_out[3:0];
      end
      next_delta = next_delta | rise_evt;
   end

   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         delta <= 4'h0;
      end
      else
      begin
         delta <= next_delta;
      end
   end

   assign modem_irq_out = |delta;

   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         scratch_storage        <= `UMS_RESET_BYTE;
         modem_control_register <= `UMS_RESET_CTL;
         irq_mask               <= `UMS_RESET_MASK;
      end
      else if (wr_acc)
      begin
         if (paddr_in == `UMS_OFF_SCRATCH)
         begin
            scratch_storage <= pwdata_in[7:0];
         end
         if (paddr_in == `UMS_OFF_CONTROL)
         begin
            modem_control_register <= pwdata_in[7:0];
         end
         if (paddr_in == `UMS_OFF_IRQ_MASK)
         begin
            irq_mask <= pwdata_in[1:0];
         end
      end
   end

   // Control pins come from flip-flops and are held inactive in loop-back.
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         rts_n_out  <= `UMS_PIN_IDLE;
         dtr_n_out  <= `UMS_PIN_IDLE;
         out1_n_out <= `UMS_PIN_IDLE;
         out2_n_out <= `UMS_PIN_IDLE;
      end
      else
      begin
         rts_n_out  <= ~modem_control_register[`UMS_CTL_RTS] | loop_mode;
         dtr_n_out  <= ~modem_control_register[`UMS_CTL_DTR] | loop_mode;
         out1_n_out <= ~modem_control_register[`UMS_CTL_OUT1] | loop_mode;
         out2_n_out <= ~modem_control_register[`UMS_CTL_OUT2] | loop_mode;
      end
   end

   // Transmit gate state machine.
   assign cts_block = auto_cts_enable & level.cts;
   always_comb
   begin
      next_tx_state = tx_state;
      unique case (tx_state)
         UMS_TX_RUN:
         begin
            if (cts_block && tx_char_done_in)
            begin
               next_tx_state = UMS_TX_HELD;
            end
         end
         UMS_TX_HELD:
         begin
            if (!cts_block)
            begin
               next_tx_state = UMS_TX_RUN;
            end
         end
         default:
         begin
            next_tx_state = UMS_TX_RUN;
         end
      endcase
   end

   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         tx_state <= UMS_TX_RUN;
      end
      else
      begin
         tx_state <= next_tx_state;
      end
   end

   assign tx_allow_out = (tx_state == UMS_TX_RUN) & ~(cts_block & tx_char_done_in);

   // Sticky interrupt status, cleared by a read; set wins.
   assign irq_evt[`UMS_IRQ_MODEM]  = |rise_evt;
   assign irq_evt[`UMS_IRQ_TXSTOP] = (tx_state == UMS_TX_RUN) & (next_tx_state == UMS_TX_HELD);
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         irq_stat <= 2'h0;
      end
      else if (rd_acc && paddr_in == `UMS_OFF_IRQ_STAT)
      begin
         irq_stat <= (irq_stat & ~prdata_out[1:0]) | irq_evt;
      end
      else
      begin
         irq_stat <= irq_stat | irq_evt;
      end
   end

   assign irq_out = |(irq_stat & irq_mask);

   always_comb
   begin
      rd_byte = 8'h00;
      unique case (paddr_in)
         `UMS_OFF_STATUS:   rd_byte = status_byte;
         `UMS_OFF_SCRATCH:  rd_byte = scratch_storage;
         `UMS_OFF_CONTROL:  rd_byte = modem_control_register;
         `UMS_OFF_IRQ_STAT: rd_byte = {6'h00, irq_stat};
         `UMS_OFF_IRQ_MASK: rd_byte = {6'h00, irq_mask};
         default:           rd_byte = 8'h00;
      endcase
   end

   // Read data is captured in the setup cycle and stands through the access cycle.
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         prdata_out <= `UMS_ZERO_WORD;
      end
      else if (rd_setup)
      begin
         prdata_out <= {24'h00_0000, rd_byte};
      end
      else
      begin
         prdata_out <= `UMS_ZERO_WORD;
      end
   end

   chk_flag_sets: assert property (@(posedge core_clk_in) disable iff (srst_in)
      (level.cts != pins_prev.cts) |=> delta[0])
      else $error("cts change flag not set");
   chk_read_clears: assert property (@(posedge core_clk_in) disable iff (srst_in)
      (rd_acc && paddr_in == `UMS_OFF_STATUS && rise_evt == 4'h0 && delta == prdata_out[3:0])
      |=> delta == 4'h0)
      else $error("status read did not clear flags");
   chk_cd_level: assert property (@(posedge core_clk_in) disable iff (srst_in)
      (!loop_mode && $stable(pins_sync.cd)) |-> status_byte[7] == ~pins_sync.cd)
      else $error("cd bit wrong");
   chk_ri_loop: assert property (@(posedge core_clk_in) disable iff (srst_in)
      loop_mode |-> status_byte[6] == modem_control_register[`UMS_CTL_OUT1])
      else $error("ri loop bit wrong");
   chk_dsr_loop: assert property (@(posedge core_clk_in) disable iff (srst_in)
      loop_mode |-> status_byte[5] == modem_control_register[`UMS_CTL_DTR])
      else $error("dsr loop bit wrong");
   chk_cts_loop: assert property (@(posedge core_clk_in) disable iff (srst_in)
      loop_mode |-> status_byte[4] == modem_control_register[`UMS_CTL_RTS])
      else $error("cts loop bit wrong");
   chk_tx_halt: assert property (@(posedge core_clk_in) disable iff (srst_in)
      (cts_block && tx_char_done_in) |=> !tx_allow_out)
      else $error("transmit not halted");
   chk_tx_resume: assert property (@(posedge core_clk_in) disable iff (srst_in)
      (tx_state == UMS_TX_HELD && !cts_block) |=> tx_allow_out || cts_block)
      else $error("transmit not resumed");
   chk_ri_fall: assert property (@(posedge core_clk_in) disable iff (srst_in)
      (!delta[2] && $fell(level.ri) && !rd_acc) |=> !delta[2])
      else $error("ri flag set on fall");
   chk_irq_req: assert property (@(posedge core_clk_in) disable iff (srst_in)
      modem_irq_out == (delta != 4'h0))
      else $error("modem irq mismatch");
   chk_scratch_back: assert property (@(posedge core_clk_in) disable iff (srst_in)
      (wr_acc && paddr_in == `UMS_OFF_SCRATCH) |=> scratch_storage == $past(pwdata_in[7:0]))
      else $error("scratch not stored");
   chk_set_wins: assert property (@(posedge core_clk_in) disable iff (srst_in)
      (rd_acc && paddr_in == `UMS_OFF_STATUS && rise_evt[0]) |=> delta[0])
      else $error("flag lost to read");
   chk_sync_delay: assert property (@(posedge core_clk_in) disable iff (srst_in)
      (!$past(srst_in) && !$past(srst_in, 2)) |-> pins_sync.cts == $past(cts_n_in, 2))
      else $error("sync path");
endmodule : ums_top
`default_nettype wire

/* File: test/ums_modem_model.sv */
// Purpose: Modem partner that drives the four active-low handshake pins.
// Assumes: Pins are levels; the bench asks for new levels through drive.
// Notes: Changes land just after a rising edge, unrelated to any read.
`timescale 1ns/1ps
`default_nettype none
module ums_modem_model
   import ums_pkg::*;
(
   // Clock.
   input  wire logic core_clk_in,
   // Modem pins, active low.
   output var  logic cts_n_out,
   output var  logic dsr_n_out,
   output var  logic ri_n_out,
   output var  logic cd_n_out
);
   ums_modem_s act = '0;

   // Pins idle high and show the inverse of the asserted lines.
   assign {cd_n_out, ri_n_out, dsr_n_out, cts_n_out} = ~act;

   task automatic drive(input ums_modem_s v);
      @(posedge core_clk_in);
      act <= v;
   endtask : drive
endmodule : ums_modem_model
`default_nettype wire

/* File: test/uart_modem_status_scratch_tb_top.sv */
// Purpose: Self-checking bench for ums_top.
// Assumes: Zero-wait APB slave; modem pins come from ums_modem_model.
// Notes: Prints only mismatches and the verdict.
`timescale 1ns/1ps
`default_nettype none
`include "ums_defines.svh"
module uart_modem_status_scratch_tb_top import ums_pkg::*;;
   logic        core_clk;
   logic        srst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic [3:0]  pstrb;
   logic        pready;
   logic        pslverr;
   logic        cts_n, dsr_n, ri_n, cd_n;
   logic [3:0]  ctl_n;
   logic        tx_done;
   logic        tx_allow;
   logic        modem_irq;
   logic        irq;
   logic [31:0] rdv;
   logic        errv;
   int          mismatches = 0;
   int          cmp_count = 0;

   ums_modem_model modem_u (.core_clk_in(core_clk), .cts_n_out(cts_n), .dsr_n_out(dsr_n),
      .ri_n_out(ri_n), .cd_n_out(cd_n));

   ums_top dut_u (.core_clk_in(core_clk), .srst_in(srst), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .cts_n_in(cts_n), .dsr_n_in(dsr_n), .ri_n_in(ri_n), .cd_n_in(cd_n),
      .rts_n_out(ctl_n[3]), .dtr_n_out(ctl_n[2]), .out1_n_out(ctl_n[1]),
      .out2_n_out(ctl_n[0]), .tx_char_done_in(tx_done), .tx_allow_out(tx_allow),
      .modem_irq_out(modem_irq), .irq_out(irq));

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic complete_run;
      if (mismatches == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc

   // One APB transfer; the request holds until pready is seen high.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge core_clk);
      end
      while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdv, exp);
   endtask : rd_chk

   task automatic t_scratch;
      logic [7:0] pat [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
      rd_chk(`UMS_OFF_STATUS, 32'h0);
      chk(tx_allow, 32'h1);
      foreach (pat[i])
      begin
         apb(1'b1, `UMS_OFF_SCRATCH, {24'h0, pat[i]});
         rd_chk(`UMS_OFF_SCRATCH, {24'h0, pat[i]});
      end
      apb(1'b1, `UMS_OFF_SCRATCH, 32'hFFFF_FF3C);
      rd_chk(`UMS_OFF_SCRATCH, 32'h3C);
      pstrb <= 4'hE;
      apb(1'b1, `UMS_OFF_SCRATCH, 32'h0000_00C3);
      pstrb <= 4'hF;
      rd_chk(`UMS_OFF_SCRATCH, 32'h3C);
      rd_chk(12'h804, 32'h0);
      chk(errv, 32'h1);
   endtask : t_scratch

   task automatic t_edges;
      ums_modem_s a;
      logic [3:0] f;
      for (int i = 0; i < 4; i++)
      begin
         a = ums_modem_s'(4'h1 << i);
         f = (i == 2) ? 4'h0 : a;
         modem_u.drive(a);
         cyc(6);
         chk(modem_irq, 32'(i != 2));
         rd_chk(`UMS_OFF_STATUS, {24'h0, a, f});
         rd_chk(`UMS_OFF_STATUS, {24'h0, a, 4'h0});
         cyc(1);
         chk(modem_irq, 32'h0);
         modem_u.drive(4'h0);
         cyc(6);
         rd_chk(`UMS_OFF_STATUS, {28'h0, a});
         rd_chk(`UMS_OFF_STATUS, 32'h0);
      end
   endtask : t_edges

   task automatic t_race;
      logic [31:0] first;
      modem_u.drive(4'h2);
      cyc(1);
      apb(1'b0, `UMS_OFF_STATUS, 32'h0);
      first = rdv;
      apb(1'b0, `UMS_OFF_STATUS, 32'h0);
      chk((first | rdv) & 32'h2, 32'h2);
      modem_u.drive(4'h0);
      cyc(6);
      apb(1'b0, `UMS_OFF_STATUS, 32'h0);
   endtask : t_race

   task automatic t_irq;
      apb(1'b0, `UMS_OFF_IRQ_STAT, 32'h0);
      apb(1'b1, `UMS_OFF_IRQ_MASK, 32'h1);
      modem_u.drive(4'h8);
      cyc(6);
      chk(irq, 32'h1);
      rd_chk(`UMS_OFF_IRQ_STAT, 32'h1);
      apb(1'b0, `UMS_OFF_STATUS, 32'h0);
      cyc(1);
      chk({irq, modem_irq}, 32'h0);
      apb(1'b1, `UMS_OFF_IRQ_MASK, 32'h0);
      modem_u.drive(4'h0);
      cyc(6);
      chk({irq, modem_irq}, 32'h1);
      apb(1'b0, `UMS_OFF_STATUS, 32'h0);
      apb(1'b0, `UMS_OFF_IRQ_STAT, 32'h0);
   endtask : t_irq

   task automatic t_loop;
      logic [7:0] ctl [3] = '{8'h15, 8'h1A, 8'h00};
      logic [7:0] exp [3] = '{8'h50, 8'hA0, 8'hF0};
      modem_u.drive(4'hF);
      apb(1'b1, `UMS_OFF_CONTROL, 32'h05);
      cyc(2);
      chk(ctl_n, 32'h5);
      foreach (ctl[i])
      begin
         apb(1'b1, `UMS_OFF_CONTROL, {24'h0, ctl[i]});
         cyc(6);
         chk(ctl_n, 32'hF);
         apb(1'b0, `UMS_OFF_STATUS, 32'h0);
         rd_chk(`UMS_OFF_STATUS, {24'h0, exp[i]});
      end
      modem_u.drive(4'h0);
      cyc(6);
      apb(1'b0, `UMS_OFF_STATUS, 32'h0);
   endtask : t_loop

   task automatic pulse_done;
      @(posedge core_clk);
      tx_done <= 1'b1;
      @(posedge core_clk);
      tx_done <= 1'b0;
      cyc(2);
   endtask : pulse_done

   task automatic t_flow;
      apb(1'b0, `UMS_OFF_IRQ_STAT, 32'h0);
      apb(1'b1, `UMS_OFF_CONTROL, 32'h80);
      cyc(2);
      chk(tx_allow, 32'h1);
      pulse_done();
      chk(tx_allow, 32'h0);
      rd_chk(`UMS_OFF_IRQ_STAT, 32'h2);
      modem_u.drive(4'h1);
      cyc(6);
      chk(tx_allow, 32'h1);
      modem_u.drive(4'h0);
      apb(1'b1, `UMS_OFF_CONTROL, 32'h0);
      pulse_done();
      chk(tx_allow, 32'h1);
   endtask : t_flow

   task automatic t_reset;
      apb(1'b1, `UMS_OFF_CONTROL, 32'h83);
      pulse_done();
      chk({tx_allow, modem_irq}, 32'h1);
      @(posedge core_clk);
      srst <= 1'b1;
      cyc(2);
      srst <= 1'b0;
      chk({tx_allow, modem_irq, irq, ctl_n}, 32'h4F);
      rd_chk(`UMS_OFF_SCRATCH, 32'h0);
      rd_chk(`UMS_OFF_CONTROL, 32'h0);
      rd_chk(`UMS_OFF_STATUS, 32'h0);
   endtask : t_reset

   initial
   begin
      #300us;
      mismatches++;
      complete_run();
   end

   initial
   begin
      srst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hF;
      tx_done = 1'b0;
      repeat (20) @(posedge core_clk);
      srst <= 1'b0;
      t_scratch();
      t_edges();
      t_race();
      t_irq();
      t_loop();
      t_flow();
      t_reset();
      complete_run();
   end
endmodule : uart_modem_status_scratch_tb_top
`default_nettype wire
